/* pkg/sdrc_defines.svh */
// Register map, field positions, reset values and filter constants
`ifndef SDRC_DEFINES_SVH
`define SDRC_DEFINES_SVH

`define SDRC_OFF_CONFIG   8'h00
`define SDRC_OFF_CHANNEL  8'h04
`define SDRC_OFF_STATUS   8'h08
`define SDRC_OFF_RESULT   8'h0C

`define SDRC_FS_LSB       0
`define SDRC_FS_MSB       9
`define SDRC_AVG_LO_BIT   10
`define SDRC_AVG_HI_BIT   11
`define SDRC_CHOP_BIT     12
`define SDRC_NOTCH_BIT    13
`define SDRC_CHAN_MSB     3

`define SDRC_FS_RESET     10'h060
`define SDRC_FS_ZERO      10'h000
`define SDRC_DECIM        20'h00400
`define SDRC_SINC3_WIN    5'h03
`define SDRC_SINC4_WIN    5'h04
`define SDRC_AVG_NONE     5'h00
`define SDRC_AVG_2        5'h02
`define SDRC_AVG_8        5'h08
`define SDRC_AVG_16       5'h10

`define SDRC_RES_W        24
`define SDRC_FIFO_DEPTH   8

`endif

/* pkg/sdrc_pkg.sv */
// Types shared by the sinc rate controller modules
`include "sdrc_defines.svh"

package sdrc_pkg;

   typedef logic [`SDRC_FS_MSB:`SDRC_FS_LSB] sdrc_fs_t;
   typedef logic [`SDRC_RES_W-1:0]           sdrc_result_t;

   typedef enum logic [1:0] {
      SDRC_ST_RESTART = 2'b00,
      SDRC_ST_SETTLE  = 2'b01,
      SDRC_ST_RUN     = 2'b10
   } sdrc_conv_st_t;

   typedef struct packed {
      logic     sixty_hertz_notch_enable;
      logic     chop_enable;
      logic     postfilter_average_select_high;
      logic     postfilter_average_select_low;
      sdrc_fs_t filter_rate_word;
   } sdrc_cfg_t;

endpackage : sdrc_pkg

/* verilog/sdrc_fifo.sv */
// Result FIFO with valid/ready on both sides
`timescale 1ns/1ps

module sdrc_fifo #(
   parameter int W = 24,
   parameter int D = 8
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic      [W-1:0] o_out_data
);
   import sdrc_pkg::*;

   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wr;
      logic [AW-1:0]       rd;
      logic [AW:0]         cnt;
   } sdrc_fifo_state_t;

   sdrc_fifo_state_t q, d;
   logic             push;
   logic             pop;

   // Honest flags straight from the fill count
   assign o_in_ready  = q.cnt != (AW+1)'(D);
   assign o_out_valid = q.cnt != '0;
   assign o_out_data  = q.mem[q.rd];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   // Pointer wrap assumes depth is a power of two
   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wr] = i_in_data;
         d.wr        = q.wr + 1'b1;
      end
      if (pop) begin
         d.rd = q.rd + 1'b1;
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule : sdrc_fifo

/* verilog/sdrc_window_tick.sv */
// Sinc window divider: one tick every 1024 times rate-word clocks
`timescale 1ns/1ps

module sdrc_window_tick (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_run,
   input  wire logic             i_clear,
   input  wire sdrc_pkg::sdrc_fs_t i_rate_word,
   output logic                  o_tick
);
   import sdrc_pkg::*;

   typedef struct packed {
      logic [19:0] cnt;
   } sdrc_tick_state_t;

   sdrc_tick_state_t q, d;
   logic [19:0]      limit;

   // Window length; rate word of zero is refused upstream
   assign limit  = 20'(i_rate_word) * `SDRC_DECIM - 20'h00001;
   assign o_tick = i_run & ~i_clear & (q.cnt >= limit);

   // Counter freezes while stalled, restarts on clear
   always_comb begin
      d = q;
      if (i_clear) begin
         d.cnt = '0;
      end else if (o_tick) begin
         d.cnt = '0;
      end else if (i_run) begin
         d.cnt = q.cnt + 20'h00001;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule : sdrc_window_tick

/* verilog/sdrc_top.sv */
// Sinc decimation rate and settling control with APB registers and result FIFO
`timescale 1ns/1ps

module sdrc_top (
   input  wire logic                   I_CORE_CLK,
   input  wire logic                   I_RST_N,
   input  wire logic                   I_PSEL,
   input  wire logic                   I_PENABLE,
   input  wire logic                   I_PWRITE,
   input  wire logic [7:0]             I_PADDR,
   input  wire logic [31:0]            I_PWDATA,
   output logic      [31:0]            O_PRDATA,
   output logic                        O_PREADY,
   output logic                        O_PSLVERR,
   input  wire logic                   I_MOD_BIT,
   output logic                        O_MOD_RESET,
   output logic                        O_CHOP_SWAP,
   output logic                        O_CONV_STROBE,
   output logic                        O_RESULT_VALID,
   input  wire logic                   I_RESULT_READY,
   output sdrc_pkg::sdrc_result_t      O_RESULT_DATA
);
   import sdrc_pkg::*;

   typedef struct packed {
      sdrc_cfg_t          cfg;
      logic [3:0]         channel;
      sdrc_conv_st_t      st;
      logic               bit_meta;
      logic               bit_sync;
      logic signed [21:0] acc;
      logic [4:0]         win_cnt;
      logic signed [25:0] post_sum;
      logic               chop_phase;
      sdrc_result_t       prev_out;
      sdrc_result_t       result;
      logic               strobe;
      logic               mod_reset;
      logic               rate_rejected;
      logic [31:0]        prdata;
      logic               slverr;
   } sdrc_core_state_t;

   sdrc_core_state_t   q, d;
   logic               tick;
   logic               run;
   logic               fifo_in_ready;
   logic               setup;
   logic               access_wr;
   logic               miss;
   logic [31:0]        rd_word;
   logic [4:0]         avg_cnt;
   logic               fast_mode;
   logic [4:0]         win_total;
   logic               last_win;
   logic signed [21:0] acc_next;
   logic signed [25:0] sum_next;
   sdrc_result_t       cur_out;
   logic signed [24:0] pair_sum;
   sdrc_result_t       final_out;

   // APB phases; slave never inserts wait states
   assign setup     = I_PSEL & ~I_PENABLE;
   assign access_wr = I_PSEL & I_PENABLE & I_PWRITE;
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = I_PSEL & I_PENABLE & q.slverr;
   assign O_PRDATA  = q.prdata;

   // Pin-facing outputs straight from flops
   assign O_MOD_RESET   = q.mod_reset;
   assign O_CHOP_SWAP   = q.chop_phase;
   assign O_CONV_STROBE = q.strobe;

   // Address decode and read mux
   always_comb begin
      miss = 1'b0;
      case (I_PADDR)
         `SDRC_OFF_CONFIG: begin
            rd_word = {18'h00000, q.cfg};
         end
         `SDRC_OFF_CHANNEL: begin
            rd_word = {28'h0000000, q.channel};
         end
         `SDRC_OFF_STATUS: begin
            rd_word = {22'h000000, O_RESULT_VALID, q.win_cnt, q.chop_phase,
                       q.rate_rejected, q.st};
         end
         `SDRC_OFF_RESULT: begin
            rd_word = {{8{q.result[`SDRC_RES_W-1]}}, q.result};
         end
         default: begin
            rd_word = 32'h00000000;
            miss    = 1'b1;
         end
      endcase
   end

   // Postfilter length from the two select bits
   always_comb begin
      case ({q.cfg.postfilter_average_select_high, q.cfg.postfilter_average_select_low})
         2'b01:   avg_cnt = `SDRC_AVG_2;
         2'b10:   avg_cnt = `SDRC_AVG_8;
         2'b11:   avg_cnt = `SDRC_AVG_16;
         default: avg_cnt = `SDRC_AVG_NONE;
      endcase
   end

   // Windows per result: sinc3 path with no average selected, or sinc4 plus postfilter
   assign fast_mode = avg_cnt != `SDRC_AVG_NONE;
   assign win_total = fast_mode ? `SDRC_SINC4_WIN + avg_cnt - 5'h01
                                : `SDRC_SINC3_WIN;
   assign last_win  = q.win_cnt == win_total - 5'h01;

   // Stall the whole conversion while the FIFO is full
   assign run = fifo_in_ready & (q.st != SDRC_ST_RESTART);

   // Window divider, 1024 x rate word clocks per sinc window
   sdrc_window_tick u_tick (
      .i_clk       (I_CORE_CLK),
      .i_rst_n     (I_RST_N),
      .i_run       (run),
      .i_clear     (q.st == SDRC_ST_RESTART),
      .i_rate_word (q.cfg.filter_rate_word),
      .o_tick      (tick)
   );

   // De-chop: swapped input counts with opposite sign
   always_comb begin
      if (q.bit_sync ^ q.chop_phase) begin
         acc_next = q.acc + 22'sh000001;
      end else begin
         acc_next = q.acc - 22'sh000001;
      end
   end

   // Postfilter sum and scaling to the result width
   assign sum_next  = q.post_sum + 26'(acc_next);
   assign cur_out   = sum_next[25:2];
   assign pair_sum  = 25'(signed'(cur_out)) + 25'(signed'(q.prev_out));

   // Chop and notch both average two successive conversions
   always_comb begin
      if (q.cfg.chop_enable | q.cfg.sixty_hertz_notch_enable) begin
         final_out = pair_sum[24:1];
      end else begin
         final_out = cur_out;
      end
   end

   // Main next-state logic
   always_comb begin
      d           = q;
      d.strobe    = 1'b0;
      d.mod_reset = 1'b0;
      // Pin synchroniser, second stage only feeds the filter
      d.bit_meta  = I_MOD_BIT;
      d.bit_sync  = q.bit_meta;
      // Read data captured in setup, shown in the access cycle
      if (setup) begin
         d.prdata = I_PWRITE ? 32'h00000000 : rd_word;
         d.slverr = miss;
      end
      // Conversion runs every cycle so an unrelated write never drops a window tick
      case (q.st)
         SDRC_ST_RESTART: begin
            // Flush filter state and pulse modulator reset
            d.acc        = '0;
            d.post_sum   = '0;
            d.win_cnt    = '0;
            d.chop_phase = 1'b0;
            d.prev_out   = '0;
            d.mod_reset  = 1'b1;
            // Chop needs a discarded first period to settle
            if (q.cfg.chop_enable) begin
               d.st = SDRC_ST_SETTLE;
            end else begin
               d.st = SDRC_ST_RUN;
            end
         end
         SDRC_ST_SETTLE, SDRC_ST_RUN: begin
            // Free running: input steps never restart the filter
            if (tick) begin
               d.acc      = '0;
               d.post_sum = sum_next;
               d.win_cnt  = q.win_cnt + 5'h01;
               if (last_win) begin
                  d.post_sum = '0;
                  d.win_cnt  = '0;
                  d.prev_out = cur_out;
                  if (q.cfg.chop_enable) begin
                     d.chop_phase = ~q.chop_phase;
                  end
                  if (q.st == SDRC_ST_SETTLE) begin
                     d.st = SDRC_ST_RUN;
                  end else begin
                     d.result = final_out;
                     d.strobe = 1'b1;
                  end
               end
            end else if (run) begin
               d.acc = acc_next;
            end
         end
         default: begin
            d.st = SDRC_ST_RESTART;
         end
      endcase
      // Register writes; a restart request overrides the conversion step
      if (access_wr) begin
         case (I_PADDR)
            `SDRC_OFF_CONFIG: begin
               if (I_PWDATA[`SDRC_FS_MSB:`SDRC_FS_LSB] == `SDRC_FS_ZERO) begin
                  d.rate_rejected = 1'b1;
               end else begin
                  d.cfg.filter_rate_word = I_PWDATA[`SDRC_FS_MSB:`SDRC_FS_LSB];
                  d.cfg.postfilter_average_select_low  = I_PWDATA[`SDRC_AVG_LO_BIT];
                  d.cfg.postfilter_average_select_high = I_PWDATA[`SDRC_AVG_HI_BIT];
                  d.cfg.chop_enable                    = I_PWDATA[`SDRC_CHOP_BIT];
                  d.cfg.sixty_hertz_notch_enable       = I_PWDATA[`SDRC_NOTCH_BIT];
                  d.rate_rejected = 1'b0;
                  d.st            = SDRC_ST_RESTART;
                  d.strobe        = 1'b0;
               end
            end
            `SDRC_OFF_CHANNEL: begin
               d.channel = I_PWDATA[`SDRC_CHAN_MSB:0];
               d.st      = SDRC_ST_RESTART;
               d.strobe  = 1'b0;
            end
            default: begin
               d.channel = q.channel;
            end
         endcase
      end
   end

   // State register; restart sequence runs after reset
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         q                      <= '0;
         q.cfg.filter_rate_word <= `SDRC_FS_RESET;
      end else begin
         q <= d;
      end
   end

   // Results queue for the host; a full queue stalls conversion
   sdrc_fifo #(
      .W (`SDRC_RES_W),
      .D (`SDRC_FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (I_CORE_CLK),
      .i_rst_n     (I_RST_N),
      .i_in_valid  (q.strobe),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (q.result),
      .o_out_valid (O_RESULT_VALID),
      .i_out_ready (I_RESULT_READY),
      .o_out_data  (O_RESULT_DATA)
   );

endmodule : sdrc_top

/* dv/sdrc_mod_model.sv */
// Modulator bitstream model: three ones in four, inverted on swap
`timescale 1ns/1ps

module sdrc_mod_model (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_mod_reset,
   input  wire logic i_chop_swap,
   output logic      o_mod_bit
);
   logic [1:0] ph_q;

   // Phase restarts with the filter so every window sees one pattern
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ph_q <= 2'h0;
      end else if (i_mod_reset) begin
         ph_q <= 2'h0;
      end else begin
         ph_q <= ph_q + 2'h1;
      end
   end

   // Swapped inputs flip the polarity seen by the modulator
   assign o_mod_bit = (ph_q != 2'h3) ^ i_chop_swap;
endmodule : sdrc_mod_model

/* dv/sdrc_monitor.sv */
// Port checker for the sinc rate controller, with its bind
`timescale 1ns/1ps
`include "sdrc_defines.svh"

module sdrc_monitor (
   input wire logic                   I_CORE_CLK,
   input wire logic                   I_RST_N,
   input wire logic                   I_PSEL,
   input wire logic                   I_PENABLE,
   input wire logic                   I_PWRITE,
   input wire logic [7:0]             I_PADDR,
   input wire logic                   I_RESULT_READY,
   input wire logic                   O_PREADY,
   input wire logic                   O_PSLVERR,
   input wire logic                   O_MOD_RESET,
   input wire logic                   O_CONV_STROBE,
   input wire logic                   O_RESULT_VALID,
   input wire sdrc_pkg::sdrc_result_t O_RESULT_DATA
);
   import sdrc_pkg::*;
   logic [15:0] gap_q;
   logic [15:0] gap_d;

   // Cycles since restart or last result, saturating so it never wraps
   always_comb begin
      gap_d = (O_MOD_RESET || O_CONV_STROBE) ? 16'h0000 : gap_q + {15'h0000, ~&gap_q};
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         gap_q <= 16'h0000;
      end else begin
         gap_q <= gap_d;
      end
   end

   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_N);

   strobe_pulse_a: assert property (O_CONV_STROBE |=> !O_CONV_STROBE)
      else $error("result strobe longer than one cycle");
   restart_pulse_a: assert property (O_MOD_RESET |=> !O_MOD_RESET)
      else $error("restart pulse longer than one cycle");
   restart_quiet_a: assert property (O_MOD_RESET |-> !O_CONV_STROBE)
      else $error("result together with restart");
   chan_restart_a: assert property (I_PSEL && I_PENABLE && I_PWRITE &&
      I_PADDR == `SDRC_OFF_CHANNEL |-> ##[1:3] O_MOD_RESET) else $error("no restart on channel");
   result_gap_a: assert property (O_CONV_STROBE |-> gap_q >= 16'h0BFF)
      else $error("results closer than three windows");
   valid_push_a: assert property (O_CONV_STROBE |=> O_RESULT_VALID)
      else $error("result not queued");
   head_hold_a: assert property (O_RESULT_VALID && !I_RESULT_READY
      |=> O_RESULT_VALID && $stable(O_RESULT_DATA)) else $error("queue head moved");
   no_wait_a: assert property (I_PSEL && I_PENABLE |-> O_PREADY)
      else $error("bus wait state");
   err_access_a: assert property (O_PSLVERR |-> I_PSEL && I_PENABLE)
      else $error("bus error outside access");

   // Main scenarios reached
   c_res: cover property (O_CONV_STROBE);
   c_err: cover property (O_PSLVERR);
   c_pop: cover property (O_RESULT_VALID && I_RESULT_READY);
endmodule : sdrc_monitor

bind sdrc_top sdrc_monitor u_mon (
   .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
   .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_RESULT_READY(I_RESULT_READY),
   .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_MOD_RESET(O_MOD_RESET),
   .O_CONV_STROBE(O_CONV_STROBE), .O_RESULT_VALID(O_RESULT_VALID),
   .O_RESULT_DATA(O_RESULT_DATA)
);

/* dv/tb.sv */
// Testbench for the sinc rate controller: registers, timing and result queue
`timescale 1ns/1ps
`include "sdrc_defines.svh"

module tb;
   import sdrc_pkg::*;
   logic         clk = 1'b0;
   logic         rst_n, psel, pen, pwr, rdy, mbit, mrst, swp, stb, rv, pready, perr, er, hit, sw;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata, rd;
   sdrc_result_t rdata;
   int           bad_count = 0;
   int           n_tests = 0;
   int           cyc = 0;
   int           c, n, i, av;

   sdrc_top u_dut (
      .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(perr), .I_MOD_BIT(mbit), .O_MOD_RESET(mrst), .O_CHOP_SWAP(swp),
      .O_CONV_STROBE(stb), .O_RESULT_VALID(rv), .I_RESULT_READY(rdy), .O_RESULT_DATA(rdata)
   );
   sdrc_mod_model u_mod (
      .i_clk(clk), .i_rst_n(rst_n), .i_mod_reset(mrst), .i_chop_swap(swp), .o_mod_bit(mbit)
   );

   // Steady master clock, 100 ns
   always #50 clk = ~clk;

   // Hang guard, about fifteen percent above the planned run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 95000) begin
         bad_count++;
         test_done();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done

   // One APB transfer; an idle edge first so the select never reasserts in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb

   // Cycles until restart (which 0) or result strobe (which 1), sampled mid-cycle
   task automatic wait_sig(input int lim, input logic which);
      c = 0;
      hit = 1'b0;
      while (!hit && c < lim) begin
         @(negedge clk);
         c++;
         hit = which ? (stb === 1'b1) : (mrst === 1'b1);
      end
   endtask : wait_sig

   // First result lands a few cycles around the whole-period figure
   task automatic near(input int e);
      chk({31'h0, hit && c + 2 >= e && c <= e + 4}, 32'h1);
   endtask : near

   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      rdy = 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      // Reset rate word, unmapped access, refused zero rate word
      apb(1'b0, `SDRC_OFF_CONFIG, 32'h0);
      chk(rd, 32'h00000060);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, `SDRC_OFF_CONFIG, 32'h0);
      apb(1'b0, `SDRC_OFF_STATUS, 32'h0);
      chk({31'h0, rd[2]}, 32'h1);
      apb(1'b0, `SDRC_OFF_CONFIG, 32'h0);
      chk(rd, 32'h00000060);
      // Chopped sinc3 with host stalled: settle, fill the queue, then drain it
      apb(1'b1, `SDRC_OFF_CONFIG, 32'h00001001);
      apb(1'b1, `SDRC_OFF_CHANNEL, 32'h00000003);
      wait_sig(20, 1'b0);
      wait_sig(8000, 1'b1);
      near(6144);
      sw = swp;
      for (i = 0; i < 7; i++) begin
         wait_sig(4000, 1'b1);
         chk(c, 3072);
         chk({31'h0, swp}, {31'h0, ~sw});
         sw = swp;
      end
      wait_sig(4000, 1'b1);
      chk({31'h0, hit}, 32'h0);
      n = 0;
      @(posedge clk);
      rdy <= 1'b1;
      // Queue outputs read mid-cycle, where they are settled
      repeat (12) begin
         @(negedge clk);
         if (rv === 1'b1 && rdy === 1'b1) begin
            n++;
            chk({31'h0, rdata[`SDRC_RES_W-1]}, 32'h0);
         end
      end
      chk(n, 8);
      chk({31'h0, rv}, 32'h0);
      // Fast settling, every average code, restarted by a channel change
      for (i = 1; i < 4; i++) begin
         av = (i == 1) ? 2 : ((i == 2) ? 8 : 16);
         apb(1'b1, `SDRC_OFF_CONFIG, {18'h0, i == 2, 1'b0, 2'(i), 10'h001});
         apb(1'b1, `SDRC_OFF_CHANNEL, 32'(i));
         wait_sig(20, 1'b0);
         wait_sig(21000, 1'b1);
         near((3 + av) * 1024);
      end
      // Fast settling with chop: same spacing, two periods to settle
      apb(1'b1, `SDRC_OFF_CONFIG, 32'h00001401);
      wait_sig(20, 1'b0);
      wait_sig(12000, 1'b1);
      near(10240);
      wait_sig(6000, 1'b1);
      chk(c, 5120);
      test_done();
   end
endmodule : tb
